//--- smc_defs.svh
// Constants of the sleep mode controller
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
`define SMC_ADDR_CTRL     12'h000
`define SMC_ADDR_STAT     12'h004
`define SMC_CTRL_RST      8'h00
`define SMC_CTRL_SLP_EN   7
`define SMC_CTRL_MODE_HI  6
`define SMC_CTRL_MODE_LO  4
`define SMC_STAT_T2U      7
`define SMC_STAT_SLP      8
`define SMC_HALT_CYC      5'h04
`define SMC_STBY_CYC      5'h06
`define SMC_RC_CYC        5'h06
`define SMC_XTAL_CYC      5'h12
`define SMC_XTAL_FUSE_MIN 4'h5
`define SMC_NWAKE         7
`define SMC_W_EXT         0
`define SMC_W_TWO_WIRE    1
`define SMC_W_T2          2
`define SMC_W_SPM         3
`define SMC_W_ADC         4
`define SMC_W_IO          5
`define SMC_W_CMP         6
`define SMC_WM_NR         7'h1F
`define SMC_WM_PD         7'h03
`endif

//--- smc_pkg.sv
// Types of the sleep mode controller
package smc_pkg;
    typedef enum logic [2:0] {
        MD_IDLE  = 3'h0,
        MD_ADCNR = 3'h1,
        MD_PDOWN = 3'h2,
        MD_PSAVE = 3'h3,
        MD_RSV4  = 3'h4,
        MD_RSV5  = 3'h5,
        MD_STBY  = 3'h6,
        MD_XSTBY = 3'h7
    } smc_mode_t;
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_SLEEP = 4'h2,
        ST_START = 4'h4,
        ST_HALT  = 4'h8
    } smc_state_t;
endpackage

//--- smc_ctl_if.sv
// Interface between the controller and its wake filter and delay counter
`timescale 1ns/1ps
`default_nettype none
interface smc_ctl_if;
    smc_pkg::smc_mode_t mode;
    logic [6:0]         src;
    logic               t2Async;
    logic               cmpDis;
    logic               hit;
    logic               load;
    logic [4:0]         loadVal;
    logic               done;
    modport top  (output mode, src, t2Async, cmpDis, load, loadVal, input hit, done);
    modport qual (input mode, src, t2Async, cmpDis, output hit);
    modport cnt  (input load, loadVal, output done);
endinterface
`default_nettype wire

//--- smc_wake_qual.sv
// Wake source filter per sleep mode
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_wake_qual (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Controller side
    smc_ctl_if.qual   ctl
);
    import smc_pkg::*;
    logic [6:0] mask;
    logic [6:0] t2Bit;
    assign t2Bit = ctl.t2Async ? 7'h04 : 7'h00;
    always_comb
    begin
        case (ctl.mode)
            MD_IDLE:  mask = ctl.cmpDis ? 7'h3F : 7'h7F;
            MD_ADCNR: mask = `SMC_WM_NR;
            MD_PDOWN: mask = `SMC_WM_PD;
            MD_STBY:  mask = `SMC_WM_PD;
            MD_PSAVE: mask = `SMC_WM_PD | t2Bit;
            MD_XSTBY: mask = `SMC_WM_PD | t2Bit;
            default:  mask = 7'h00;
        endcase
    end
    assign ctl.hit = |(ctl.src & mask);
    pd_filter_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ctl.hit && ctl.mode == MD_PDOWN) |-> (ctl.src[1:0] != 2'h0))
        else $error("power-down wake from a blocked source");
endmodule
`default_nettype wire

//--- smc_delay_cnt.sv
// Down counter timing start-up and core halt
`timescale 1ns/1ps
`default_nettype none
module smc_delay_cnt (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic ce,
    // Controller side
    smc_ctl_if.cnt    ctl
);
    logic [4:0] cnt_r;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cnt_r <= 5'h00;
        else if (ce)
        begin
            if (ctl.load)
                cnt_r <= ctl.loadVal;
            else if (cnt_r != 5'h00)
                cnt_r <= cnt_r - 5'h01;
        end
    end
    // Last cycle of the loaded span
    assign ctl.done = (cnt_r == 5'h01);
endmodule
`default_nettype wire

//--- smc_top.sv
// Sleep mode controller with APB control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_top (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        ce,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core handshake
    input  wire logic        sleepInstr,
    input  wire logic        sleepReset,
    output logic             coreHalt,
    output logic             irqRun,
    output logic             resetWake,
    output logic             sleeping,
    // Peripheral settings
    input  wire logic        comparatorDisable,
    input  wire logic        timer2AsyncSelect,
    input  wire logic        adcEnabled,
    // Pins
    input  wire logic [6:0]  wakePins,
    input  wire logic [3:0]  clockSourceFuses,
    // Clock domain gates, oscillator enables, comparator power-down and conversion start
    output logic             coreClockDomainEn,
    output logic             programMemClockDomainEn,
    output logic             ioClockDomainEn,
    output logic             converterClockDomainEn,
    output logic             asyncClockDomainEn,
    output logic             mainOscEn,
    output logic             timerOscEn,
    output logic             comparatorPowerDown,
    output logic             adcStart
);
    import smc_pkg::*;

    smc_ctl_if ctl ();

    smc_wake_qual uQual (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ctl     (ctl.qual)
    );

    smc_delay_cnt uCnt (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .ctl     (ctl.cnt)
    );

    // Pin synchroniser; wake levels must outlast it
    logic [10:0] syncA_r;
    logic [10:0] syncB_r;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            syncA_r <= 11'h000;
            syncB_r <= 11'h000;
        end
        else if (ce)
        begin
            syncA_r <= {clockSourceFuses, wakePins};
            syncB_r <= syncA_r;
        end
    end

    logic [6:0] wakeSync;
    logic [3:0] fuseSync;
    logic       crystalSel;
    assign wakeSync   = syncB_r[6:0];
    assign fuseSync   = syncB_r[10:7];
    assign crystalSel = (fuseSync >= `SMC_XTAL_FUSE_MIN);

    // Registers
    logic [7:0] ctrl_r;
    logic       t2Undef_r;
    smc_state_t state_r;
    smc_state_t stateNxt;
    smc_mode_t  actMode_r;
    smc_mode_t  modeNxt;

    // Entry decode
    logic [2:0] selCode;
    logic       modeRsv;
    logic       stbyCode;
    logic       entryOk;
    logic       takeSleep;
    assign selCode   = ctrl_r[`SMC_CTRL_MODE_HI:`SMC_CTRL_MODE_LO];
    assign modeRsv   = selCode[2] & ~selCode[1];
    assign stbyCode  = selCode[2] & selCode[1];
    assign entryOk   = ctrl_r[`SMC_CTRL_SLP_EN] & ~modeRsv
                     & (~stbyCode | crystalSel);
    assign takeSleep = (state_r == ST_RUN) & sleepInstr & entryOk;
    assign modeNxt   = takeSleep ? smc_mode_t'(selCode) : actMode_r;

    // Wake decode
    logic shallow;
    logic stbyMode;
    logic saveMode;
    logic wakeTake;
    logic resetTake;
    logic startEnd;
    logic haltEnd;
    logic [4:0] startCyc;
    assign shallow   = (actMode_r == MD_IDLE) | (actMode_r == MD_ADCNR);
    assign stbyMode  = (actMode_r == MD_STBY) | (actMode_r == MD_XSTBY);
    assign saveMode  = (actMode_r == MD_PSAVE) | (actMode_r == MD_XSTBY);
    assign resetTake = (state_r != ST_RUN) & sleepReset;
    assign wakeTake  = (state_r == ST_SLEEP) & ~sleepReset & ctl.hit;
    assign startEnd  = (state_r == ST_START) & ~sleepReset & ctl.done;
    assign haltEnd   = (state_r == ST_HALT) & ~sleepReset & ctl.done;
    assign startCyc  = stbyMode ? `SMC_STBY_CYC :
                       (crystalSel ? `SMC_XTAL_CYC : `SMC_RC_CYC);

    assign ctl.mode    = actMode_r;
    assign ctl.src     = wakeSync;
    assign ctl.t2Async = timer2AsyncSelect;
    assign ctl.cmpDis  = comparatorDisable;
    assign ctl.load    = wakeTake | startEnd;
    assign ctl.loadVal = (wakeTake & ~shallow) ? startCyc : `SMC_HALT_CYC;

    // Sequencer; wake never clears core storage
    always_comb
    begin
        stateNxt = state_r;
        case (state_r)
            ST_RUN:
                if (takeSleep)
                    stateNxt = ST_SLEEP;
            ST_SLEEP:
                if (resetTake)
                    stateNxt = ST_RUN;
                else if (wakeTake)
                    stateNxt = shallow ? ST_HALT : ST_START;
            ST_START:
                if (resetTake)
                    stateNxt = ST_RUN;
                else if (startEnd)
                    stateNxt = ST_HALT;
            ST_HALT:
                if (resetTake | haltEnd)
                    stateNxt = ST_RUN;
            default:
                stateNxt = ST_RUN;
        endcase
    end

    // Clock gating from the next state so gates move with it
    logic asleepN;
    logic deepN;
    logic mIdle;
    logic mNr;
    logic mLowOsc;
    logic mAsy;
    assign asleepN = (stateNxt == ST_SLEEP);
    assign deepN   = asleepN | (stateNxt == ST_START);
    assign mIdle   = (modeNxt == MD_IDLE);
    assign mNr     = (modeNxt == MD_ADCNR);
    assign mLowOsc = (modeNxt == MD_PDOWN) | (modeNxt == MD_PSAVE);
    assign mAsy    = (modeNxt == MD_PSAVE) | (modeNxt == MD_XSTBY);

    logic coreEnNxt;
    logic ioEnNxt;
    logic adcEnNxt;
    logic asyEnNxt;
    logic oscEnNxt;
    logic tOscEnNxt;
    logic cmpOffNxt;
    logic adcGoNxt;
    assign coreEnNxt = ~deepN;
    assign ioEnNxt   = ~deepN | (asleepN & mIdle);
    assign adcEnNxt  = ~deepN | (asleepN & (mIdle | mNr));
    assign asyEnNxt  = ~deepN | (asleepN & (mIdle | mNr))
                     | (asleepN & mAsy & timer2AsyncSelect);
    assign oscEnNxt  = ~asleepN | ~mLowOsc;
    assign tOscEnNxt = timer2AsyncSelect & (~asleepN | mIdle | mNr | mAsy);
    assign cmpOffNxt = comparatorDisable | (asleepN & ~mIdle);
    assign adcGoNxt  = takeSleep & adcEnabled
                     & ((selCode == MD_IDLE) | (selCode == MD_ADCNR));

    // APB decode, zero wait states
    logic setup;
    logic access;
    logic ctrlSel;
    logic statSel;
    logic wrCtrl;
    logic wrStat;
    logic t2Set;
    logic t2Clr;
    logic [31:0] statVal;
    logic [31:0] rdVal;
    assign setup   = psel & ~penable;
    assign access  = psel & penable & pready;
    assign ctrlSel = (paddr == `SMC_ADDR_CTRL);
    assign statSel = (paddr == `SMC_ADDR_STAT);
    assign wrCtrl  = access & pwrite & ctrlSel;
    assign wrStat  = access & pwrite & statSel;
    assign statVal = {23'h000000, sleeping, t2Undef_r, actMode_r, state_r};
    assign rdVal   = ctrlSel ? {24'h000000, ctrl_r} : (statSel ? statVal : 32'h00000000);
    assign t2Set   = wakeTake & saveMode & ~timer2AsyncSelect;
    assign t2Clr   = wrStat & pwdata[`SMC_STAT_T2U];

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else if (ce)
        begin
            pready  <= setup;
            pslverr <= setup & ~(ctrlSel | statSel);
            prdata  <= (setup & ~pwrite) ? rdVal : 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ctrl_r    <= `SMC_CTRL_RST;
            t2Undef_r <= 1'b0;
        end
        else if (ce)
        begin
            if (wrCtrl)
                ctrl_r <= pwdata[7:0];
            // Set wins over a clear in the same cycle
            if (t2Set)
                t2Undef_r <= 1'b1;
            else if (t2Clr)
                t2Undef_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_r   <= ST_RUN;
            actMode_r <= MD_IDLE;
        end
        else if (ce)
        begin
            state_r   <= stateNxt;
            actMode_r <= modeNxt;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            coreClockDomainEn       <= 1'b1;
            programMemClockDomainEn <= 1'b1;
            ioClockDomainEn         <= 1'b1;
            converterClockDomainEn  <= 1'b1;
            asyncClockDomainEn      <= 1'b1;
            mainOscEn               <= 1'b1;
            timerOscEn              <= 1'b0;
            comparatorPowerDown     <= 1'b0;
            adcStart                <= 1'b0;
            coreHalt                <= 1'b0;
            irqRun                  <= 1'b0;
            resetWake               <= 1'b0;
            sleeping                <= 1'b0;
        end
        else if (ce)
        begin
            coreClockDomainEn       <= coreEnNxt;
            programMemClockDomainEn <= coreEnNxt;
            ioClockDomainEn         <= ioEnNxt;
            converterClockDomainEn  <= adcEnNxt;
            asyncClockDomainEn      <= asyEnNxt;
            mainOscEn               <= oscEnNxt;
            timerOscEn              <= tOscEnNxt;
            comparatorPowerDown     <= cmpOffNxt;
            adcStart                <= adcGoNxt;
            coreHalt                <= (stateNxt == ST_HALT);
            irqRun                  <= haltEnd;
            resetWake               <= resetTake;
            sleeping                <= (stateNxt != ST_RUN);
        end
    end

    // Checks, with the clock enable held high
    entry_gate_a: assert property (@(posedge clk_sys) disable iff (srst || !ce)
        (state_r == ST_RUN && sleepInstr && !ctrl_r[`SMC_CTRL_SLP_EN])
            |=> (state_r == ST_RUN && !sleeping))
        else $error("sleep taken with enable bit clear");

    reserved_skip_a: assert property (@(posedge clk_sys) disable iff (srst || !ce)
        (state_r == ST_RUN && sleepInstr && modeRsv) |=> !sleeping)
        else $error("reserved mode code entered sleep");

    halt_four_a: assert property (@(posedge clk_sys) disable iff (srst || !ce || sleepReset)
        $rose(coreHalt) |-> coreHalt[*4] ##1 (!coreHalt && irqRun))
        else $error("core halt not four cycles before interrupt");

    reset_wake_a: assert property (@(posedge clk_sys) disable iff (srst || !ce)
        (sleeping && sleepReset) |=> (resetWake && !sleeping && !irqRun))
        else $error("reset in sleep did not restart core");

    idle_clocks_a: assert property (@(posedge clk_sys) disable iff (srst || !ce)
        (state_r == ST_SLEEP && actMode_r == MD_IDLE)
            |-> (!coreClockDomainEn && !programMemClockDomainEn
                 && ioClockDomainEn && converterClockDomainEn && mainOscEn))
        else $error("idle clock gating wrong");

    nr_clocks_a: assert property (@(posedge clk_sys) disable iff (srst || !ce)
        (state_r == ST_SLEEP && actMode_r == MD_ADCNR)
            |-> (!ioClockDomainEn && !coreClockDomainEn && converterClockDomainEn))
        else $error("noise mode clock gating wrong");

    pd_clocks_a: assert property (@(posedge clk_sys) disable iff (srst || !ce)
        (state_r == ST_SLEEP && actMode_r == MD_PDOWN)
            |-> (!mainOscEn && !asyncClockDomainEn && !converterClockDomainEn))
        else $error("power-down left a clock running");

    standby_osc_a: assert property (@(posedge clk_sys) disable iff (srst || !ce)
        (state_r == ST_SLEEP && actMode_r == MD_STBY)
            |-> (mainOscEn && !coreClockDomainEn && !timerOscEn))
        else $error("standby oscillator state wrong");

    adc_start_a: assert property (@(posedge clk_sys) disable iff (srst || !ce)
        (takeSleep && adcEnabled && selCode == MD_ADCNR) |=> (adcStart && sleeping))
        else $error("conversion not started on noise mode entry");

    cmp_off_a: assert property (@(posedge clk_sys) disable iff (srst || !ce)
        (state_r == ST_SLEEP && $past(comparatorDisable)) |-> comparatorPowerDown)
        else $error("comparator not powered down");

    idle_wake_c: cover property (@(posedge clk_sys) disable iff (srst)
        (state_r == ST_SLEEP && actMode_r == MD_IDLE) ##1 coreHalt);
    pd_wake_c: cover property (@(posedge clk_sys) disable iff (srst)
        (state_r == ST_START && actMode_r == MD_PDOWN) ##[1:40] irqRun);
    reset_wake_c: cover property (@(posedge clk_sys) disable iff (srst) resetWake);
endmodule
`default_nettype wire

//--- smc_core_model.sv
// Processor core model that issues sleep and times the halt after wake
`timescale 1ns/1ps
`default_nettype none
module smc_core_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Test side
    input  wire logic       go,
    output logic      [7:0] haltLen,
    // Controller side
    input  wire logic       sleeping,
    input  wire logic       coreHalt,
    input  wire logic       irqRun,
    output logic            sleepInstr
);
    logic [7:0] haltCnt_r;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sleepInstr <= 1'b0;
            haltCnt_r  <= 8'h00;
            haltLen    <= 8'h00;
        end
        else
        begin
            // A real core cannot execute sleep while it is stopped
            sleepInstr <= go && !sleeping;
            haltCnt_r  <= coreHalt ? haltCnt_r + 8'h01 : 8'h00;
            if (irqRun)
                haltLen <= haltCnt_r;
        end
    end
endmodule
`default_nettype wire

//--- sleep_mode_controller_tb_top.sv
// Self-checking bench for the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller_tb_top;
    logic        clk_sys = 1'b0, srst = 1'b1, go = 1'b0, er;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleepReset = 1'b0;
    logic        cmpDis = 1'b0, t2Async = 1'b0, adcEn = 1'b0, ce = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [6:0]  wakePins = 7'h00;
    logic [3:0]  fuses = 4'h8;
    logic [31:0] prdata;
    logic [7:0]  haltLen;
    logic        pready, pslverr, sleepInstr, coreHalt, irqRun, resetWake, sleeping;
    logic        cmpPd, adcStart;
    wire  [6:0]  gates;
    int          fails = 0, totalChecks = 0;
    always #2.5 clk_sys = ~clk_sys;
    smc_top uut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleepInstr(sleepInstr),
        .sleepReset(sleepReset), .coreHalt(coreHalt), .irqRun(irqRun),
        .resetWake(resetWake), .sleeping(sleeping), .comparatorDisable(cmpDis),
        .timer2AsyncSelect(t2Async), .adcEnabled(adcEn), .wakePins(wakePins),
        .clockSourceFuses(fuses), .coreClockDomainEn(gates[6]),
        .programMemClockDomainEn(gates[5]), .ioClockDomainEn(gates[4]),
        .converterClockDomainEn(gates[3]), .asyncClockDomainEn(gates[2]),
        .mainOscEn(gates[1]), .timerOscEn(gates[0]), .comparatorPowerDown(cmpPd),
        .adcStart(adcStart));
    smc_core_model core (.clk_sys(clk_sys), .srst(srst), .go(go), .haltLen(haltLen),
        .sleeping(sleeping), .coreHalt(coreHalt), .irqRun(irqRun), .sleepInstr(sleepInstr));
    task automatic testDone;
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            fails++;
            testDone();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One sleep instruction from the core, outputs sampled once settled
    task automatic doSleep;
        @(posedge clk_sys);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic noSleep(input logic [7:0] c);
        apb(1'b1, 12'h000, {24'h0, c});
        doSleep();
        chk("refusedSleep", 32'h0, sleeping);
    endtask
    // Order {core, flash, io, converter, async, main osc, timer osc}
    function automatic logic [6:0] expGates(input logic [2:0] m, input logic a);
        case (m)
            3'h0: return {4'h3, 2'h3, a};
            3'h1: return {4'h1, 2'h3, a};
            3'h2: return 7'h00;
            3'h3: return {4'h0, a, 1'b0, a};
            3'h6: return 7'h02;
            default: return {4'h0, a, 1'b1, a};
        endcase
    endfunction
    // bb is a source that must not wake this mode, -1 for none
    task automatic sleepWake(input logic [2:0] m, input int wb, input int bb, input int lat);
        int n;
        apb(1'b1, 12'h000, {24'h0, 1'b1, m, 4'h0});
        doSleep();
        chk("sleeping", 32'h1, sleeping);
        chk("gates", expGates(m, t2Async), gates);
        chk("cmpPowerDown", (m == 3'h0) ? cmpDis : 1'b1, cmpPd);
        chk("adcStart", (m < 3'h2) & adcEn, adcStart);
        apb(1'b0, 12'h004, 32'h0);
        chk("status", {23'h0, 1'b1, 1'b0, m, 4'h2}, rd);
        if (bb >= 0)
        begin
            wakePins <= 7'h01 << bb;
            repeat (12) @(posedge clk_sys);
            #1;
            chk("ignoredWake", 32'h1, sleeping);
        end
        @(posedge clk_sys);
        // Level held until the core runs, long enough for every mode
        wakePins <= 7'h01 << wb;
        for (n = 1; n <= 60; n++)
        begin
            @(posedge clk_sys);
            #1;
            if (irqRun === 1'b1)
                break;
        end
        if (n > 60)
        begin
            fails++;
            testDone();
        end
        chk("wakeLatency", lat, n);
        @(posedge clk_sys);
        wakePins <= 7'h00;
        #1;
        chk("haltCycles", 32'h4, haltLen);
        chk("awake", 32'h0, sleeping);
        chk("clocksBack", 32'h3F, gates[6:1]);
        // Stored control bits survive the whole sleep and wake
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrlKept", {24'h0, 1'b1, m, 4'h0}, rd);
        apb(1'b1, 12'h000, 32'h0);
    endtask
    initial
    begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrlReset", 32'h0, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("statusReset", 32'h1, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmappedErr", 32'h1, er);
        noSleep(8'h7F);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrlReadBack", 32'h7F, rd);
        noSleep(8'hC0);
        noSleep(8'hD0);
        @(posedge clk_sys);
        fuses <= 4'h2;
        noSleep(8'hE0);
        noSleep(8'hF0);
        @(posedge clk_sys);
        fuses <= 4'h8;
        adcEn <= 1'b1;
        sleepWake(3'h0, 5, -1, 7);
        cmpDis <= 1'b1;
        sleepWake(3'h0, 0, 6, 7);
        cmpDis <= 1'b0;
        sleepWake(3'h1, 4, 5, 7);
        sleepWake(3'h2, 1, 3, 25);
        t2Async <= 1'b1;
        sleepWake(3'h3, 2, 5, 25);
        sleepWake(3'h7, 2, 5, 13);
        t2Async <= 1'b0;
        sleepWake(3'h6, 0, 2, 13);
        fuses <= 4'h2;
        sleepWake(3'h2, 0, -1, 13);
        fuses <= 4'h8;
        apb(1'b1, 12'h000, 32'hA0);
        doSleep();
        @(posedge clk_sys);
        sleepReset <= 1'b1;
        @(posedge clk_sys);
        sleepReset <= 1'b0;
        #1;
        chk("resetWake", 32'h1, resetWake);
        chk("resetAwake", 32'h0, sleeping);
        sleepWake(3'h3, 0, 2, 25);
        apb(1'b0, 12'h004, 32'h0);
        chk("t2Undefined", 32'h1, rd[7]);
        apb(1'b1, 12'h004, 32'h80);
        apb(1'b0, 12'h004, 32'h0);
        chk("t2Cleared", 32'h0, rd[7]);
        // Enable low freezes the sequencer, so a sleep request is lost
        apb(1'b1, 12'h000, 32'h80);
        ce <= 1'b0;
        doSleep();
        chk("frozenSleep", 32'h0, sleeping);
        @(posedge clk_sys);
        ce <= 1'b1;
        testDone();
    end
endmodule
`default_nettype wire
